/* File: design/qccr_regs.sv */
// capture control register bank with output standard vote
//
// Function
// - capture size field codes, 111 reserved
// - capture enable bit 3, quadrant bits 5:4
// - input standard field bits 2:0, PAL default
// - output standard follows majority of four
// - tie between NTSC and PAL selects PAL
// - lamp bits 6:0 drive LEDs, off at reset
// - major firmware revision readable as byte
// - minor firmware revision readable as byte
//
// Local design decision: the strobed register port.
`include "qccr_defs.svh"

module qccr_regs #(
  // arbitrary neutral revision values
  parameter logic [7:0] FW_MAJOR = 8'h05,
  parameter logic [7:0] FW_MINOR = 8'h03
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // decoder 4 capture controls
  output logic [2:0] captureSize,
  output logic captureEnable,
  output logic [1:0] captureQuadrant,
  // standard selection
  output logic outputIsPal,
  // lamps
  output logic [6:0] lampOn
);

  //----------------------------------------
  // state
  //----------------------------------------
  typedef struct packed {
    logic [5:0] capture;
    logic [6:0] lamp;
    logic pal;
    logic rdStd;
    logic [7:0] rdata;
  } qccr_state_t;

  qccr_state_t state;
  qccr_state_t next_state;

  logic stdWrite;
  logic [1:0] stdIdx;
  logic [2:0] stdRdata;
  logic [3*`QCCR_NUM_DEC-1:0] stdCodes;
  logic [2:0] palCount;
  logic [2:0] ntscCount;
  logic palWins;
  logic [`QCCR_NUM_DEC-1:0] decIsPal;
  logic [`QCCR_NUM_DEC-1:0] decIsNtsc;
  logic hitCapture;
  logic hitStd;
  logic hitLamp;
  logic hitMajor;
  logic hitMinor;
  logic wrCapture;
  logic wrLamp;
  logic rdCapture;
  logic rdStdReg;
  logic rdLamp;
  logic rdMajor;
  logic rdMinor;
  logic rdOther;
  logic [5:0] captureNext;
  logic [6:0] lampNext;
  logic [7:0] readValue;

  //----------------------------------------
  // address decode
  //----------------------------------------
  // one hit line per register, one shared by the four standard registers, keeps the write and read paths flat
  assign hitCapture = (regAddr == `QCCR_OFF_DEC4_CAPTURE);
  assign hitStd = (regAddr >= `QCCR_OFF_DEC1_STD) && (regAddr <= `QCCR_OFF_DEC4_STD);
  assign hitLamp = (regAddr == `QCCR_OFF_LAMP);
  assign hitMajor = (regAddr == `QCCR_OFF_FW_MAJOR);
  assign hitMinor = (regAddr == `QCCR_OFF_FW_MINOR);

  // the revision registers take no write strobe at all
  assign wrCapture = regWr && hitCapture;
  assign wrLamp = regWr && hitLamp;

  assign rdCapture = regRd && hitCapture;
  assign rdStdReg = regRd && hitStd;
  assign rdLamp = regRd && hitLamp;
  assign rdMajor = regRd && hitMajor;
  assign rdMinor = regRd && hitMinor;
  // unmapped offsets read as zero and swallow writes
  assign rdOther = regRd && !(hitCapture || hitStd || hitLamp || hitMajor || hitMinor);

  //----------------------------------------
  // standard store
  //----------------------------------------
  // one shared index: a write and a read never come together
  assign stdIdx = regAddr[1:0];
  assign stdWrite = regWr && hitStd;

  qccr_std_store #(
    .NUM(`QCCR_NUM_DEC)
  ) stdStore (
    .refClk(ref_clk),
    .rst(rst),
    .writeEn(stdWrite),
    .writeIdx(stdIdx),
    .writeData(regWdata[`QCCR_STD_MSB:`QCCR_STD_LSB]),
    .readIdx(stdIdx),
    .readData(stdRdata),
    .allCodes(stdCodes)
  );

  //----------------------------------------
  // vote
  //----------------------------------------
  // reserved codes land in neither counted bin, so they add to neither side of the vote
  for (genvar g = 0; g < `QCCR_NUM_DEC; g++) begin : g_dec
    logic [2:0] code;
    assign code = stdCodes[g*3 +: 3];
    assign decIsPal[g] = (code == qccr_pkg::QCCR_STD_PAL);
    assign decIsNtsc[g] = (code == qccr_pkg::QCCR_STD_NTSC);
  end

  // three bits hold a count of up to four decoders
  always_comb begin
    palCount = 3'h0;
    ntscCount = 3'h0;
    for (int i = 0; i < `QCCR_NUM_DEC; i++) begin
      palCount = palCount + {2'h0, decIsPal[i]};
      ntscCount = ntscCount + {2'h0, decIsNtsc[i]};
    end
  end

  // a tie goes to PAL, so the equal case sits on the PAL side
  assign palWins = (palCount >= ntscCount);

  //----------------------------------------
  // write path
  //----------------------------------------
  // reserved bits are dropped here, so they always read back as zero
  always_comb begin
    captureNext = state.capture;
    lampNext = state.lamp;
    if (wrCapture) begin
      captureNext = regWdata[`QCCR_QUAD_MSB:`QCCR_SIZE_LSB];
    end
    if (wrLamp) begin
      lampNext = regWdata[`QCCR_LAMP_MSB:`QCCR_LAMP_LSB];
    end
  end

  //----------------------------------------
  // read path
  //----------------------------------------
  // the standard codes come from the store's own read flop, not from here
  always_comb begin
    readValue = 8'h00;
    if (rdCapture) begin
      readValue = {2'h0, state.capture};
    end else if (rdLamp) begin
      readValue = {1'b0, state.lamp};
    end else if (rdMajor) begin
      readValue = FW_MAJOR;
    end else if (rdMinor) begin
      readValue = FW_MINOR;
    end else if (rdOther) begin
      readValue = 8'h00;
    end
  end

  //----------------------------------------
  // register logic
  //----------------------------------------
  always_comb begin
    next_state = state;
    next_state.capture = captureNext;
    next_state.lamp = lampNext;
    // vote follows store contents one cycle after each write
    next_state.pal = palWins;
    // read data stand for one cycle only, then fall back to zero
    next_state.rdStd = rdStdReg;
    next_state.rdata = readValue;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state.capture <= 6'(`QCCR_RST_DEC4_CAPTURE);
      state.lamp <= `QCCR_RST_LAMP;
      state.pal <= `QCCR_RST_PAL;
      state.rdStd <= 1'b0;
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  //----------------------------------------
  // outputs
  //----------------------------------------
  // store read data is itself a flop; the mux only picks between two flops
  assign regRdata = state.rdStd ? {5'h00, stdRdata} : state.rdata;
  assign captureSize = state.capture[`QCCR_SIZE_MSB:`QCCR_SIZE_LSB];
  assign captureEnable = state.capture[`QCCR_CAPEN_BIT];
  assign captureQuadrant = state.capture[`QCCR_QUAD_MSB:`QCCR_QUAD_LSB];
  assign outputIsPal = state.pal;
  assign lampOn = state.lamp;

endmodule // qccr_regs

/* File: design/qccr_defs.svh */
// register offsets, field positions and reset values of the capture control bank
`ifndef QCCR_DEFS_SVH
`define QCCR_DEFS_SVH

// register offsets
`define QCCR_OFF_DEC4_CAPTURE 8'h01
`define QCCR_OFF_DEC1_STD 8'h04
`define QCCR_OFF_DEC2_STD 8'h05
`define QCCR_OFF_DEC3_STD 8'h06
`define QCCR_OFF_DEC4_STD 8'h07
`define QCCR_OFF_LAMP 8'h08
`define QCCR_OFF_FW_MAJOR 8'h09
`define QCCR_OFF_FW_MINOR 8'h0A

// field positions
`define QCCR_SIZE_LSB 0
`define QCCR_SIZE_MSB 2
`define QCCR_CAPEN_BIT 3
`define QCCR_QUAD_LSB 4
`define QCCR_QUAD_MSB 5
`define QCCR_STD_LSB 0
`define QCCR_STD_MSB 2
`define QCCR_LAMP_LSB 0
`define QCCR_LAMP_MSB 6

// reset values
`define QCCR_RST_DEC4_CAPTURE 8'h32
`define QCCR_RST_STD 3'h1
`define QCCR_RST_LAMP 7'h00
`define QCCR_RST_PAL 1'b1

// number of decoders sharing the majority vote
`define QCCR_NUM_DEC 4

`endif

/* File: design/qccr_pkg.sv */
// types of the capture control register bank
package qccr_pkg;

  typedef enum logic [2:0] {
    QCCR_SIZE_UNSCALED = 3'h0,
    QCCR_SIZE_176X120 = 3'h1,
    QCCR_SIZE_352X240 = 3'h2,
    QCCR_SIZE_176X144 = 3'h3,
    QCCR_SIZE_352X288 = 3'h4,
    QCCR_SIZE_320X240 = 3'h5,
    QCCR_SIZE_640X480 = 3'h6,
    QCCR_SIZE_RESERVED = 3'h7
  } qccr_size_t;

  typedef enum logic [2:0] {
    QCCR_STD_NTSC = 3'h0,
    QCCR_STD_PAL = 3'h1
  } qccr_std_t;

endpackage

/* File: design/qccr_std_store.sv */
// four-entry store of the per-decoder input colour standard codes
`include "qccr_defs.svh"

module qccr_std_store #(
  parameter int NUM = `QCCR_NUM_DEC
) (
  // clock and reset
  input wire logic refClk,
  input wire logic rst,
  // write port
  input wire logic writeEn,
  input wire logic [1:0] writeIdx,
  input wire logic [2:0] writeData,
  // read port, registered
  input wire logic [1:0] readIdx,
  output logic [2:0] readData,
  // whole contents for the vote
  output logic [NUM*3-1:0] allCodes
);

  typedef struct packed {
    logic [NUM*3-1:0] codes;
    logic [2:0] rdata;
  } qccr_store_state_t;

  qccr_store_state_t state;
  qccr_store_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.rdata = state.codes[readIdx*3 +: 3];
    if (writeEn) begin
      next_state.codes[writeIdx*3 +: 3] = writeData;
    end
  end

  always_ff @(posedge refClk) begin
    if (rst) begin
      for (int i = 0; i < NUM; i++) begin
        state.codes[i*3 +: 3] <= `QCCR_RST_STD;
      end
      state.rdata <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  assign readData = state.rdata;
  assign allCodes = state.codes;

endmodule // qccr_std_store

/* File: test/qccr_regs_chk.sv */
// port assertions of the capture control bank
module qccr_regs_chk #(parameter logic [7:0] FW_MAJOR = 8'h05, FW_MINOR = 8'h03) (
  // watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] captureSize,
  input wire logic captureEnable,
  input wire logic [1:0] captureQuadrant,
  input wire logic outputIsPal,
  input wire logic [6:0] lampOn
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic stdWr = regWr && regAddr[7:2] == 6'h01;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence capWr; regWr && regAddr == 8'h01; endsequence
  a_size_write:
    assert property (capWr |=> captureSize == $past(regWdata[2:0])) else $error("size");
  a_enable_write:
    assert property (capWr |=> captureEnable == $past(regWdata[3])) else $error("enable");
  a_quad_write:
    assert property (capWr |=> captureQuadrant == $past(regWdata[5:4])) else $error("quad");
  a_lamp_write:
    assert property (regWr && regAddr == 8'h08 |=> lampOn == $past(regWdata[6:0])) else $error("lamp");
  a_major_read:
    assert property (regRd && regAddr == 8'h09 |=> regRdata == FW_MAJOR) else $error("major");
  a_minor_read:
    assert property (regRd && regAddr == 8'h0A |=> regRdata == FW_MINOR) else $error("minor");
  a_idle_read:
    assert property (!regRd |=> regRdata == 8'h00) else $error("stray data");
  a_vote_timing:
    assert property ($changed(outputIsPal) && !$past(rst) |-> $past(stdWr, 2))
      else $error("vote time");
  // reference copy of the four standard codes, kept from the write strobes
  logic [2:0] mirror [4];
  int palN;
  int ntscN;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mirror <= '{default: 3'h1};
    end else if (stdWr) begin
      mirror[regAddr[1:0]] <= regWdata[2:0];
    end
  end
  always_comb begin
    palN = 0;
    ntscN = 0;
    foreach (mirror[k]) begin
      palN += int'(mirror[k] == 3'h1);
      ntscN += int'(mirror[k] == 3'h0);
    end
  end
  wire logic mirrorPal = palN >= ntscN;
  a_vote_value:
    assert property (!$past(rst) |-> outputIsPal == $past(mirrorPal))
      else $error("vote value");
endmodule // qccr_regs_chk

bind qccr_regs qccr_regs_chk #(.FW_MAJOR(FW_MAJOR), .FW_MINOR(FW_MINOR)) chk (.*);

/* File: test/quad_capture_control_regs_test.sv */
// bench of the capture control bank
module quad_capture_control_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a, d, w;} qccr_row_t;
  logic ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, outputIsPal, captureEnable;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, v;
  logic [2:0] captureSize;
  logic [1:0] captureQuadrant;
  logic [6:0] lampOn;
  int errorCnt = 0, nCompared = 0;
  qccr_row_t rows [6] = '{'{8'h01, 8'hC4, 8'h04}, '{8'h08, 8'hFF, 8'h7F},
    '{8'h04, 8'hFF, 8'h07}, '{8'h09, 8'hAA, 8'h05}, '{8'h0A, 8'h55, 8'h03},
    '{8'h0F, 8'h12, 8'h00}};
  qccr_regs dut (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(logic [7:0] g, e);
    nCompared++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic finalReport;
    $display("compared %0d failed %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang is cut short long after the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge ref_clk);
    errorCnt++;
    finalReport();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk({1'b0, outputIsPal, captureQuadrant, captureEnable, captureSize}, 8'h72);
    for (int a = 1; a < 9; a++) begin
      rd(8'(a));
      chk(v, a == 1 ? 8'h32 : {7'h00, a > 3 && a < 8});
    end
    for (int i = 0; i < 64; i++) begin
      wr(8'h01, 8'(i));
      rd(8'h01);
      chk(v, 8'(i));
      chk({2'b00, captureQuadrant, captureEnable, captureSize}, 8'(i));
    end
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a);
      chk(v, rows[r].w);
    end
    chk({1'b0, lampOn}, 8'h7F);
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 4; k++) wr(8'h04 + 8'(k), {7'h00, i[k]});
      // the vote shows one edge after the store takes the last write
      @(posedge ref_clk);
      #1 chk({7'h00, outputIsPal}, {7'h00, $countones(i[3:0]) > 1});
    end
    // reserved codes must count for neither side of the vote
    for (int k = 0; k < 3; k++) wr(8'h04 + 8'(k), 8'h05);
    wr(8'h07, 8'h00);
    @(posedge ref_clk);
    #1 chk({7'h00, outputIsPal}, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk({outputIsPal, lampOn}, 8'h80);
    chk({2'b00, captureQuadrant, captureEnable, captureSize}, 8'h32);
    rd(8'h07);
    chk(v, 8'h01);
    finalReport();
  end
endmodule // quad_capture_control_regs_test
